//--- logic/spi_port_pkg.sv
// Constants for the serial port: register word addresses, field positions,
// divider limits, state codes.
// Assumes a single 125 MHz peripheral clock that also times the serial clock.
package spi_port_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register word addresses
    localparam logic [15:0] ADDR_CONFIG_CONTROL    = 16'h7040;
    localparam logic [15:0] ADDR_OPERATION_CONTROL = 16'h7041;
    localparam logic [15:0] ADDR_PORT_STATUS       = 16'h7042;
    localparam logic [15:0] ADDR_BIT_RATE_DIVIDER  = 16'h7044;
    localparam logic [15:0] ADDR_RECEIVE_DEBUG     = 16'h7046;
    localparam logic [15:0] ADDR_RECEIVE_BUFFER    = 16'h7047;
    localparam logic [15:0] ADDR_TRANSMIT_BUFFER   = 16'h7048;
    localparam logic [15:0] ADDR_SHIFT_DATA        = 16'h7049;
    localparam logic [15:0] ADDR_TX_QUEUE_CONTROL  = 16'h704a;
    localparam logic [15:0] ADDR_RX_QUEUE_CONTROL  = 16'h704b;
    localparam logic [15:0] ADDR_QUEUE_DELAY       = 16'h704c;
    localparam logic [15:0] ADDR_PRIORITY_CONTROL  = 16'h704f;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int CCR_POLARITY_BIT = 6;
    localparam int CCR_LEN_LSB      = 0;
    localparam int CTL_TALK_BIT     = 1;
    localparam int CTL_MASTER_BIT   = 2;
    localparam int CTL_PHASE_BIT    = 3;
    localparam int STS_OVERRUN_BIT  = 7;
    localparam int STS_RX_FULL_BIT  = 6;
    localparam int STS_TX_FULL_BIT  = 5;
    localparam int STS_BUSY_BIT     = 0;
    localparam int RXQ_CLR_OVR_BIT  = 6;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [7:0] CONFIG_RESET    = 8'h07;
    localparam logic [7:0] OPERATION_RESET = 8'h00;
    localparam logic [6:0] DIVIDER_RESET   = 7'h00;
    localparam logic [7:0] BYTE_RESET      = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Divider and data path
    localparam logic [7:0] DIV_FIXED_PERIOD = 8'h04;
    localparam logic [6:0] DIV_FIXED_MAX    = 7'h02;
    localparam logic [7:0] DIV_PERIOD_MAX   = 8'h80;
    localparam int         WORD_BITS        = 16;
    localparam int         DATA_BITS        = 8;
    localparam int         FIFO_DEPTH       = 16;

    ////////////////////////////////////////////////////////////////////////////
    // Transfer engine states
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_LEAD  = 3'b010,
        ST_SHIFT = 3'b100
    } xfer_state_e;

endpackage : spi_port_pkg

//--- logic/stream_if.sv
// Valid/ready word stream between the register side and the queue.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
`default_nettype none

interface stream_if #(parameter int W = 8) ();
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : stream_if

`default_nettype wire

//--- logic/word_queue.sv
// Transmit word queue with a registered output word.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none

module word_queue #(
    parameter int W     = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     reset,
    // Streams
    stream_if.snk                         in_s,
    stream_if.src                         out_s,
    // Fill level
    output logic [$clog2(DEPTH+1)-1:0]    level
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);

    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [CW-1:0] cnt_q;
    logic          out_valid_q;
    logic [W-1:0]  out_data_q;

    wire push = in_s.valid && in_s.ready;
    wire pop  = out_valid_q && out_s.ready;
    wire load = (cnt_q != '0) && (!out_valid_q || pop);

    assign in_s.ready  = cnt_q != CW'(DEPTH);
    assign out_s.valid = out_valid_q;
    assign out_s.data  = out_data_q;
    assign level       = CW'(cnt_q + CW'(out_valid_q));

    ////////////////////////////////////////////////////////////////////////////
    // Storage
    always_ff @(posedge clk)
    begin
        if (push)
            mem[wr_ptr_q] <= in_s.data;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            wr_ptr_q    <= '0;
            rd_ptr_q    <= '0;
            cnt_q       <= '0;
            out_valid_q <= 1'b0;
            out_data_q  <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_q <= AW'(wr_ptr_q + 1'b1);
            if (load)
            begin
                rd_ptr_q   <= AW'(rd_ptr_q + 1'b1);
                out_data_q <= mem[rd_ptr_q];
            end
            cnt_q       <= CW'(cnt_q + CW'(push) - CW'(load));
            out_valid_q <= load || (out_valid_q && !pop);
        end
    end

endmodule : word_queue

`default_nettype wire

//--- logic/spi_master_clock_and_select.sv
// Serial port: register frame, master serial clock, select and shifting.
// Assumes clk is the peripheral clock and the register port is word wide.
//
// Operation
// R1: Twelve port registers decode at word addresses from 0x7040 per the table.
// R2: Software uses only 16-bit accesses; 32-bit accesses are undefined.
// R3: Clock period is four cycles for divider 0..2, else divider plus one.
// R4: Even periods span 4 to 128 cycles, odd periods 5 to 127.
// R5: Odd periods: first half is half a cycle short, second half long.
// R6: Operation control bit 2 selects master, bit 3 delays data half a cycle; here bit 3 delays the serial clock half a cycle, data timing is unchanged.
// R7: Configuration bit 6 sets clock polarity and so the active edge.
// R8: Select goes low at least half a period before the first clock edge.
// R9: Select rises half a period after the last bit's receiving edge.
// R10: Back-to-back transmit words keep select low between them.
// R11: Software keeps the clock within 15 MHz transmit, 10 MHz receive.
// R12: As slave, the external master drives select low for a transfer; no slave mode here, transfers run only as master.
// R13: Data sits in bits 7..0; upper byte reads zero, writes ignored.
// R14: Words of one to sixteen bits shift both ways; transmit can be disabled.
// R15: Clock is whole cycles and rests at idle level between words.
`timescale 1ns/1ns
`default_nettype none

module spi_master_clock_and_select (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // Register port
    input  wire logic [15:0] reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [15:0] reg_wdata,
    output logic      [15:0] reg_rdata,
    // Serial pins
    output logic             serial_clock,
    output logic             serial_clock_oe,
    output logic             master_out_line,
    output logic             master_out_oe,
    input  wire logic        master_in_line,
    output logic             slave_select_n,
    output logic             slave_select_oe
);
    ////////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [7:0] half_len(input logic [7:0] period, input logic second);
        logic [7:0] first;
        first    = {1'b0, period[7:1]};
        half_len = second ? 8'(period - first) : first;
    endfunction : half_len
    ////////////////////////////////////////////////////////////////////////////
    // Registers
    logic [7:0]  config_q;
    logic [7:0]  operation_q;
    logic [6:0]  divider_q;
    logic [7:0]  queue_delay_q;
    logic [7:0]  priority_q;
    logic [15:0] rx_word_q;
    logic        rx_full_q;
    logic        overrun_q;
    logic [15:0] rdata_q;
    spi_port_pkg::xfer_state_e state_q;
    logic [7:0]  cnt_q;
    logic        half_q;
    logic [4:0]  bit_q;
    logic [15:0] tx_shift_q;
    logic [15:0] rx_shift_q;
    logic        sclk_q;
    logic        mosi_q;
    logic        ss_n_q;
    logic        in_s1_q;
    logic        in_s2_q;
    logic        in_s3_q;
    logic        miso_q;
    stream_if #(.W(spi_port_pkg::DATA_BITS)) fill_s ();
    stream_if #(.W(spi_port_pkg::DATA_BITS)) drain_s ();
    logic [4:0]  tx_level;
    ////////////////////////////////////////////////////////////////////////////
    // Decode
    wire hit_ccr  = reg_addr == spi_port_pkg::ADDR_CONFIG_CONTROL;     // R1
    wire hit_ctl  = reg_addr == spi_port_pkg::ADDR_OPERATION_CONTROL;  // R1
    wire hit_sts  = reg_addr == spi_port_pkg::ADDR_PORT_STATUS;        // R1
    wire hit_brr  = reg_addr == spi_port_pkg::ADDR_BIT_RATE_DIVIDER;   // R1
    wire hit_emu  = reg_addr == spi_port_pkg::ADDR_RECEIVE_DEBUG;      // R1
    wire hit_rxb  = reg_addr == spi_port_pkg::ADDR_RECEIVE_BUFFER;     // R1
    wire hit_txb  = reg_addr == spi_port_pkg::ADDR_TRANSMIT_BUFFER;    // R1
    wire hit_dat  = reg_addr == spi_port_pkg::ADDR_SHIFT_DATA;         // R1
    wire hit_ftx  = reg_addr == spi_port_pkg::ADDR_TX_QUEUE_CONTROL;   // R1
    wire hit_frx  = reg_addr == spi_port_pkg::ADDR_RX_QUEUE_CONTROL;   // R1
    wire hit_fct  = reg_addr == spi_port_pkg::ADDR_QUEUE_DELAY;        // R1
    wire hit_pri  = reg_addr == spi_port_pkg::ADDR_PRIORITY_CONTROL;   // R1

    wire [7:0] wbyte     = reg_wdata[7:0];                           // R13
    wire       master    = operation_q[spi_port_pkg::CTL_MASTER_BIT]; // R6
    wire       phase     = operation_q[spi_port_pkg::CTL_PHASE_BIT];  // R6
    wire       talk      = operation_q[spi_port_pkg::CTL_TALK_BIT];   // R14
    wire       polarity  = config_q[spi_port_pkg::CCR_POLARITY_BIT];  // R7
    wire [4:0] word_bits = 5'(config_q[3:0]) + 5'h01;                 // R14
    wire       busy      = state_q != spi_port_pkg::ST_IDLE;
    wire [7:0] rd_byte =
        hit_ccr ? config_q :
        hit_ctl ? operation_q :
        hit_sts ? {overrun_q, rx_full_q, !fill_s.ready, 4'h0, busy} :
        hit_brr ? {1'b0, divider_q} :
        (hit_emu || hit_rxb) ? rx_word_q[7:0] :
        hit_dat ? tx_shift_q[15:8] :
        hit_ftx ? {3'h0, tx_level} :
        hit_frx ? {1'b0, overrun_q, 5'h00, rx_full_q} :
        hit_fct ? queue_delay_q :
        hit_pri ? priority_q :
        spi_port_pkg::BYTE_RESET;
    ////////////////////////////////////////////////////////////////////////////
    // Divider
    wire [7:0] period = (divider_q <= spi_port_pkg::DIV_FIXED_MAX) ?
                        spi_port_pkg::DIV_FIXED_PERIOD : 8'(divider_q) + 8'h01;  // R3 R4
    wire [7:0] cur_len  = half_len(period, (state_q == spi_port_pkg::ST_LEAD) || half_q); // R5
    wire       half_end = busy && (cnt_q == 8'(cur_len - 8'h01));                  // R15
    wire       last_bit = bit_q == 5'(word_bits - 5'h01);
    wire       word_end = (state_q == spi_port_pkg::ST_SHIFT) && half_end && half_q && last_bit;
    wire       next_go  = master && drain_s.valid;                                 // R10
    wire       start    = (state_q == spi_port_pkg::ST_IDLE) && next_go;
    assign drain_s.ready = start || (word_end && next_go);
    wire [15:0] load_word = 16'(drain_s.data) << (5'd16 - word_bits);
    ////////////////////////////////////////////////////////////////////////////
    // Queue
    assign fill_s.valid = reg_wr && (hit_txb || hit_dat);
    assign fill_s.data  = wbyte;
    word_queue #(.W(spi_port_pkg::DATA_BITS), .DEPTH(spi_port_pkg::FIFO_DEPTH))
        u_tx_queue (.clk(clk), .reset(reset), .in_s(fill_s), .out_s(drain_s), .level(tx_level));
    ////////////////////////////////////////////////////////////////////////////
    // Register writes and reads
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            config_q      <= spi_port_pkg::CONFIG_RESET;
            operation_q   <= spi_port_pkg::OPERATION_RESET;
            divider_q     <= spi_port_pkg::DIVIDER_RESET;
            queue_delay_q <= spi_port_pkg::BYTE_RESET;
            priority_q    <= spi_port_pkg::BYTE_RESET;
            rdata_q       <= '0;
        end
        else
        begin
            if (reg_wr && hit_ccr)
                config_q <= wbyte;                                          // R7
            if (reg_wr && hit_ctl)
                operation_q <= wbyte;                                       // R6
            if (reg_wr && hit_brr)
                divider_q <= wbyte[6:0];                                    // R3
            if (reg_wr && hit_fct)
                queue_delay_q <= wbyte;
            if (reg_wr && hit_pri)
                priority_q <= wbyte;
            if (reg_rd)
                rdata_q <= {8'h00, rd_byte};                                // R13
        end
    end

    assign reg_rdata = rdata_q;
    ////////////////////////////////////////////////////////////////////////////
    // Receive flags, set wins over clear
    wire rx_clear  = reg_rd && hit_rxb;
    wire ovr_clear = reg_wr && ((hit_sts && wbyte[spi_port_pkg::STS_OVERRUN_BIT]) ||
                                (hit_frx && wbyte[spi_port_pkg::RXQ_CLR_OVR_BIT]));

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            rx_word_q <= '0;
            rx_full_q <= 1'b0;
            overrun_q <= 1'b0;
        end
        else
        begin
            if (word_end)
                rx_word_q <= rx_shift_q;                                    // R14
            rx_full_q <= word_end || (rx_full_q && !rx_clear);
            overrun_q <= (word_end && rx_full_q && !rx_clear) || (overrun_q && !ovr_clear);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Input synchroniser
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            in_s1_q <= 1'b0;
            in_s2_q <= 1'b0;
            in_s3_q <= 1'b0;
            miso_q  <= 1'b0;
        end
        else
        begin
            in_s1_q <= master_in_line;
            in_s2_q <= in_s1_q;
            in_s3_q <= in_s2_q;
            if (in_s2_q == in_s3_q)
                miso_q <= in_s3_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transfer engine
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state_q    <= spi_port_pkg::ST_IDLE;
            cnt_q      <= '0;
            half_q     <= 1'b0;
            bit_q      <= '0;
            tx_shift_q <= '0;
            rx_shift_q <= '0;
        end
        else
        begin
            cnt_q <= (half_end || !busy) ? 8'h00 : 8'(cnt_q + 8'h01);      // R15
            unique case (state_q)
                spi_port_pkg::ST_IDLE:
                begin
                    if (start)                                              // R6
                    begin
                        state_q    <= spi_port_pkg::ST_LEAD;
                        tx_shift_q <= load_word;
                        bit_q      <= '0;
                        half_q     <= 1'b0;
                    end
                end
                spi_port_pkg::ST_LEAD:
                begin
                    if (half_end)                                           // R8
                        state_q <= spi_port_pkg::ST_SHIFT;
                end
                spi_port_pkg::ST_SHIFT:
                begin
                    if (half_end && !half_q)
                    begin
                        half_q     <= 1'b1;
                        rx_shift_q <= {rx_shift_q[14:0], miso_q};           // R14
                    end
                    else if (half_end)
                    begin
                        half_q <= 1'b0;
                        if (!last_bit)
                        begin
                            bit_q      <= 5'(bit_q + 5'h01);
                            tx_shift_q <= {tx_shift_q[14:0], 1'b0};
                        end
                        else if (next_go)                                   // R10
                        begin
                            bit_q      <= '0;
                            tx_shift_q <= load_word;
                        end
                        else
                            state_q <= spi_port_pkg::ST_IDLE;               // R9
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin registers
    wire active_half = phase ? half_q : !half_q;                            // R6
    wire sclk_d      = polarity ^ ((state_q == spi_port_pkg::ST_SHIFT) && active_half); // R7

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            sclk_q <= 1'b0;
            mosi_q <= 1'b0;
            ss_n_q <= 1'b1;
        end
        else
        begin
            sclk_q <= sclk_d;                                               // R15
            mosi_q <= tx_shift_q[15];
            ss_n_q <= !busy;                                                // R8
        end
    end

    assign serial_clock    = sclk_q;
    assign master_out_line = mosi_q;
    assign slave_select_n  = ss_n_q;
    assign serial_clock_oe = master;
    assign slave_select_oe = master;
    assign master_out_oe   = master && talk;                                // R14
    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    logic [7:0] lead_cnt_q;
    always_ff @(posedge clk)
    begin
        if (reset || ss_n_q)
            lead_cnt_q <= '0;
        else if (lead_cnt_q != 8'hff)
            lead_cnt_q <= 8'(lead_cnt_q + 8'h01);
    end

    sequence word_done_s;
        word_end && !next_go;
    endsequence
    sequence word_chain_s;
        word_end && next_go;
    endsequence
    a_decode_config: assert property (reg_wr && hit_ccr |=> config_q == $past(reg_wdata[7:0])) // R1
        else $error("config register write lost");
    a_period_rule: assert property (period == ((divider_q <= 7'h02) ? 8'h04 : 8'(divider_q) + 8'h01)) // R3
        else $error("serial period wrong");
    a_period_range: assert property (period >= 8'h04 && period <= 8'h80 && !(period[0] && period < 8'h05)) // R4
        else $error("serial period out of range");
    a_half_split: assert property (state_q == spi_port_pkg::ST_SHIFT && half_end && !half_q
                                   |-> 8'(cnt_q + cnt_q + 8'h02 + 8'(period[0])) == period) // R5
        else $error("first half length wrong");
    a_master_gate: assert property (!master && state_q == spi_port_pkg::ST_IDLE |=> state_q == spi_port_pkg::ST_IDLE) // R6
        else $error("transfer started outside master mode");
    a_idle_polarity: assert property (state_q != spi_port_pkg::ST_SHIFT |=> serial_clock == $past(polarity)) // R7
        else $error("clock left idle level");
    a_select_lead: assert property ($changed(serial_clock) && serial_clock != polarity && !$past(reset) // R8
                                    |-> !ss_n_q && lead_cnt_q >= {1'b0, period[7:1]})
        else $error("select not early enough");
    a_select_trail: assert property (word_done_s |=> state_q == spi_port_pkg::ST_IDLE ##1 ss_n_q) // R9
        else $error("select not released after last bit");
    a_select_hold: assert property (word_chain_s |=> !ss_n_q [*2]) // R10
        else $error("select dropped between words");
    a_upper_zero: assert property (reg_rd |=> reg_rdata[15:8] == 8'h00) // R13
        else $error("upper byte not zero");
    a_talk_off: assert property (!talk |-> !master_out_oe) // R14
        else $error("transmit driven while disabled");
    a_rx_set_wins: assert property (word_end |=> rx_full_q) // R14
        else $error("receive flag lost");

endmodule : spi_master_clock_and_select

`default_nettype wire

//--- sim/spi_slave_model.sv
// Behavioural serial slave on the port's pins.
// Assumes mode inputs match the port's polarity and phase.
`timescale 1ns/1ns
`default_nettype none

module spi_slave_model (
    // Pins
    input  wire logic       serial_clock,
    input  wire logic       slave_select_n,
    input  wire logic       master_out_line,
    output logic            master_in_line,
    // Mode and data
    input  wire logic       pol,
    input  wire logic       phase,
    input  wire logic [7:0] reply,
    output logic      [7:0] got
);
    logic [2:0] idx;

    initial
    begin
        master_in_line = 1'b0;
        got = 8'h00;
        idx = 3'h7;
    end
    always @(negedge slave_select_n)
    begin
        idx = 3'h7;
        master_in_line = reply[7];
    end
    // Released line shows the inverse of its last value
    always @(posedge slave_select_n)
        master_in_line = ~master_in_line;
    always @(serial_clock)
    begin
        if (!slave_select_n && serial_clock === (pol ^ phase))
        begin
            got = {got[6:0], master_out_line};
            idx = idx - 3'h1;
            master_in_line = reply[idx];
        end
    end
endmodule : spi_slave_model

`default_nettype wire

//--- sim/spi_master_clock_and_select_bench.sv
// Testbench: divider table, select framing, modes, queue fill, reset values.
// Assumes the slave model on the pins and a 125 MHz clock.
`timescale 1ns/1ns
`default_nettype none

module spi_master_clock_and_select_bench;
    logic        clk;
    logic        reset;
    logic [15:0] reg_addr;
    logic        reg_wr;
    logic        reg_rd;
    logic [15:0] reg_wdata;
    logic [15:0] reg_rdata;
    logic        sclk;
    logic        sclk_oe;
    logic        mosi;
    logic        mosi_oe;
    logic        miso;
    logic        sel_n;
    logic        sel_oe;
    logic        pol;
    logic        phase;
    logic [7:0]  reply;
    logic [7:0]  got;
    logic [15:0] v;
    int          miscompares;
    int          num_checks;
    int          n;
    int          hi;
    int          lo;
    // Divider, first half, second half
    int          rows [7][3] = '{'{0, 2, 2}, '{2, 2, 2}, '{3, 2, 2}, '{4, 2, 3}, '{12, 6, 7},
                                 '{126, 63, 64}, '{127, 64, 64}};

    spi_master_clock_and_select dut (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .serial_clock(sclk),
        .serial_clock_oe(sclk_oe), .master_out_line(mosi), .master_out_oe(mosi_oe),
        .master_in_line(miso), .slave_select_n(sel_n), .slave_select_oe(sel_oe));
    spi_slave_model peer (.serial_clock(sclk), .slave_select_n(sel_n), .master_out_line(mosi),
        .master_in_line(miso), .pol(pol), .phase(phase), .reply(reply), .got(got));

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [15:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        num_checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    // Cycles until select (s=1) or serial clock leaves level lv
    task automatic run(input logic s, input logic lv, output int c);
        c = 0;
        do
        begin
            @(posedge clk);
            #1 c++;
        end
        while (((s ? sel_n : sclk) === lv) && c < 5000);
        if (c >= 5000)
            chk(16'(c), 16'h0000);
    endtask : run
    task automatic conclude;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : conclude
    initial
    begin
        repeat (20000) @(posedge clk);
        miscompares++;
        conclude();
    end

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        {reset, reg_wr, reg_rd, pol, phase} = 5'b10000;
        {reg_addr, reg_wdata, reply} = 40'h0;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        wr(spi_port_pkg::ADDR_OPERATION_CONTROL, 16'h0006);
        chk(16'({sclk_oe, mosi_oe, sel_oe}), 16'h0007);
        foreach (rows[i])
        begin
            reply <= 8'h3c;
            wr(spi_port_pkg::ADDR_BIT_RATE_DIVIDER, 16'(rows[i][0]));
            rd(spi_port_pkg::ADDR_BIT_RATE_DIVIDER);
            chk(v, 16'(rows[i][0]));
            wr(spi_port_pkg::ADDR_TRANSMIT_BUFFER, 16'h00a5);
            run(1, 1, n);
            run(0, 0, n);
            chk(16'(n), 16'(rows[i][2]));
            run(0, 1, hi);
            run(0, 0, lo);
            chk(16'(hi + lo), 16'(rows[i][1] + rows[i][2]));
            chk(16'(hi), 16'(rows[i][1]));
            repeat (6)
            begin
                run(0, 1, n);
                run(0, 0, n);
            end
            run(0, 1, n);
            run(1, 0, n);
            chk(16'(n), 16'(rows[i][2]));
            chk(16'(got), 16'h00a5);
            rd(spi_port_pkg::ADDR_RECEIVE_BUFFER);
            if (rows[i][1] > 5)
                chk(v, 16'h003c);
        end
        $display("test divider table done");
        pol <= 1'b1;
        phase <= 1'b1;
        wr(spi_port_pkg::ADDR_CONFIG_CONTROL, 16'h0047);
        wr(spi_port_pkg::ADDR_OPERATION_CONTROL, 16'h000e);
        wr(spi_port_pkg::ADDR_BIT_RATE_DIVIDER, 16'h0007);
        run(0, 0, n);
        chk(16'(sclk), 16'h0001);
        wr(spi_port_pkg::ADDR_TRANSMIT_BUFFER, 16'h005a);
        run(1, 1, n);
        run(0, 1, n);
        chk(16'(n), 16'h0008);
        run(1, 0, n);
        chk(16'(got), 16'h005a);
        $display("test polarity phase done");
        phase <= 1'b0;
        wr(spi_port_pkg::ADDR_OPERATION_CONTROL, 16'h0000);
        repeat (20) wr(spi_port_pkg::ADDR_TRANSMIT_BUFFER, 16'h0081);
        chk(16'({sclk_oe, sel_n}), 16'h0001);
        rd(spi_port_pkg::ADDR_PORT_STATUS);
        chk(v & 16'h0020, 16'h0020);
        rd(spi_port_pkg::ADDR_TX_QUEUE_CONTROL);
        chk(v, 16'h0011);
        wr(spi_port_pkg::ADDR_OPERATION_CONTROL, 16'h0004);
        run(1, 1, n);
        chk(16'(mosi_oe), 16'h0000);
        run(1, 0, n);
        chk(16'(n >= 17 * 64), 16'h0001);
        rd(spi_port_pkg::ADDR_TX_QUEUE_CONTROL);
        chk(v, 16'h0000);
        $display("test queue fill done");
        @(posedge clk);
        reset <= 1'b1;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        rd(spi_port_pkg::ADDR_CONFIG_CONTROL);
        chk(v, 16'h0007);
        rd(spi_port_pkg::ADDR_OPERATION_CONTROL);
        chk(v | 16'({sclk, sel_n}), 16'h0001);
        wr(spi_port_pkg::ADDR_PRIORITY_CONTROL, 16'hff5a);
        rd(spi_port_pkg::ADDR_PRIORITY_CONTROL);
        chk(v, 16'h005a);
        rd(16'h7043);
        chk(v, 16'h0000);
        pol <= 1'b0;
        wr(spi_port_pkg::ADDR_CONFIG_CONTROL, 16'h0003);
        wr(spi_port_pkg::ADDR_OPERATION_CONTROL, 16'h0006);
        wr(spi_port_pkg::ADDR_TRANSMIT_BUFFER, 16'h0005);
        run(1, 1, n);
        run(1, 0, n);
        chk(16'(got[3:0]), 16'h0005);
        $display("test reset and map done");
        conclude();
    end
endmodule : spi_master_clock_and_select_bench

`default_nettype wire
